//--- hw/uaddr_pkg.sv
package uaddr_pkg;

  // ---------------------------------------------------------------
  // register map, byte addresses on the AHB-Lite slave port
  // ---------------------------------------------------------------
  localparam logic [11:0] UADDR_CTRL_ADDR     = 12'h000;
  localparam logic [11:0] UADDR_BAUD_ADDR     = 12'h004;
  localparam logic [11:0] UADDR_STAT_ADDR     = 12'h008;
  localparam logic [11:0] UADDR_RXDATA_ADDR   = 12'h00C;
  localparam logic [11:0] UADDR_INTSTAT_ADDR  = 12'h010;
  localparam logic [11:0] UADDR_INTMASK_ADDR  = 12'h014;
  // the two address registers keep their printed index; byte address is four times it
  localparam logic [9:0]  UADDR_SLAVE_ADDRESS_IDX = 10'h0A9;
  localparam logic [9:0]  UADDR_SLAVE_MASK_IDX    = 10'h0B9;
  localparam logic [11:0] UADDR_SLAVE_ADDRESS_ADDR = {UADDR_SLAVE_ADDRESS_IDX, 2'b00};
  localparam logic [11:0] UADDR_SLAVE_MASK_ADDR    = {UADDR_SLAVE_MASK_IDX, 2'b00};

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_MP_BIT     = 2;
  localparam int CTRL_RXEN_BIT   = 3;
  localparam int CTRL_FAST_BIT   = 4;
  localparam int STAT_DONE_BIT   = 0;
  localparam int STAT_NINTH_BIT  = 1;
  localparam int STAT_FE_BIT     = 2;
  localparam int STAT_BUSY_BIT   = 3;
  localparam int EV_ACCEPT_BIT   = 0;
  localparam int EV_FE_BIT       = 1;
  localparam int EV_DROP_BIT     = 2;
  localparam int EV_W            = 3;

  // ---------------------------------------------------------------
  // reset values and fixed counts
  // ---------------------------------------------------------------
  localparam logic [7:0]  SLAVE_ADDRESS_RST = 8'h00;
  localparam logic [7:0]  SLAVE_MASK_RST    = 8'h00;
  localparam logic [4:0]  CTRL_RST          = 5'h00;
  localparam logic [15:0] BAUD_RST          = 16'h0000;
  // fixed-rate mode: oversample tick every 2 (/32 bit rate) or 4 (/64) clocks
  localparam logic [15:0] FIXED_DIV_FAST    = 16'h0001;
  localparam logic [15:0] FIXED_DIV_SLOW    = 16'h0003;
  localparam logic [3:0]  VOTE_SLICE        = 4'h9;

  typedef enum logic [1:0] {
    UADDR_MODE_SYNC   = 2'b00,
    UADDR_MODE_ASYNC10 = 2'b01,
    UADDR_MODE_FIXED11 = 2'b10,
    UADDR_MODE_VAR11   = 2'b11
  } uaddr_mode_e;

  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       stop;
  } uaddr_frame_s;

endpackage : uaddr_pkg

//--- hw/uaddr_match.sv
`timescale 1ns/1ns
// given and broadcast address compare, purely combinational
module uaddr_match
  import uaddr_pkg::*;
(
  input  wire logic [7:0] byte_i,
  input  wire logic [7:0] slave_address_i,
  input  wire logic [7:0] slave_address_mask_i,
  output logic            match_o
);
  logic [7:0] bcast;
  logic       given_hit;
  logic       bcast_hit;

  // only mask ones are compared; all-zero registers match any byte
  assign given_hit = ~|((byte_i ^ slave_address_i) & slave_address_mask_i);
  // broadcast: ones of the or must be present, zeros are don't care
  assign bcast     = slave_address_i | slave_address_mask_i;
  assign bcast_hit = ~|(~byte_i & bcast);
  assign match_o   = given_hit | bcast_hit;

endmodule : uaddr_match

//--- hw/uaddr_rx_frame.sv
`timescale 1ns/1ns
// asynchronous frame receiver, 16x oversampled, 2-of-3 vote per bit
module uaddr_rx_frame
  import uaddr_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         enable_i,
  input  wire logic         tick16_i,
  input  wire logic         nine_bit_i,
  input  wire logic         rxd_i,
  output uaddr_frame_s      frame_o,
  output logic              frame_valid_o,
  output logic              busy_o
);
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } uaddr_rx_state_e;

  uaddr_rx_state_e state_reg;
  logic [3:0]      slice_reg;
  logic [3:0]      bitn_reg;
  logic [1:0]      samp_reg;
  logic [8:0]      shift_reg;
  logic            rxd_prev_reg;
  logic            vote;

  assign vote   = (samp_reg[0] & samp_reg[1]) | (rxd_i & (samp_reg[0] | samp_reg[1]));
  assign busy_o = (state_reg != RX_IDLE);

  // bit engine; every idle tick reloads the slice counter with 1, so it counts from the falling start edge to align bit boundaries
  always_ff @(posedge clk_i) begin
    frame_valid_o <= 1'b0;
    if (sys_rst_i || !enable_i) begin
      state_reg    <= RX_IDLE;
      slice_reg    <= 4'h0;
      bitn_reg     <= 4'h0;
      samp_reg     <= 2'b11;
      rxd_prev_reg <= 1'b1;
      shift_reg    <= 9'h000;
      frame_o      <= '0;
    end else if (tick16_i) begin
      rxd_prev_reg <= rxd_i;
      slice_reg    <= slice_reg + 4'h1;
      if (slice_reg == VOTE_SLICE - 4'h2) samp_reg[0] <= rxd_i;
      if (slice_reg == VOTE_SLICE - 4'h1) samp_reg[1] <= rxd_i;
      case (state_reg)
        RX_IDLE: begin
          slice_reg <= 4'h1;
          if (rxd_prev_reg && !rxd_i) state_reg <= RX_START;
        end
        RX_START: begin
          // a start bit that votes high is noise: abort and hunt again
          if (slice_reg == VOTE_SLICE) begin
            state_reg <= vote ? RX_IDLE : RX_DATA;
            bitn_reg  <= 4'h0;
          end
        end
        RX_DATA: begin
          if (slice_reg == VOTE_SLICE) begin
            shift_reg <= {vote, shift_reg[8:1]};
            bitn_reg  <= bitn_reg + 4'h1;
            if (bitn_reg == (nine_bit_i ? 4'h8 : 4'h7)) state_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          // frame ends mid stop bit so the next start edge is not missed
          if (slice_reg == VOTE_SLICE) begin
            frame_o.data  <= nine_bit_i ? shift_reg[7:0] : shift_reg[8:1];
            frame_o.ninth <= nine_bit_i ? shift_reg[8] : vote;
            frame_o.stop  <= vote;
            frame_valid_o <= 1'b1;
            state_reg     <= RX_IDLE;
          end
        end
        default: state_reg <= RX_IDLE;
      endcase
    end
  end

endmodule : uaddr_rx_frame

//--- hw/uart_address_recognition.sv
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// - In 11-bit modes an address frame has its ninth bit at one, data frames at zero.
// - With multiprocessor mode set the receive flag rises only on a given or broadcast match.
// - With multiprocessor mode clear every complete frame raises the receive flag.
// - In the 10-bit mode with multiprocessor mode set, a frame needs stop one and a match.
// - Given address compares slave address bits only where the mask bit is one.
// - Broadcast address is address or mask, its zero bits being don't care.
// - Slave address and mask registers sit at indices A9h and B9h.
// - Both address registers reset to 00h, so every byte matches.
// - A frame loads the buffer only if the flag is clear and mode is off or ninth bit is one.
module uart_address_recognition
  import uaddr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // serial line and side outputs
  input  wire logic        rxd_i,
  output logic             rx_done_flag_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [4:0]         ctrl_reg;
  logic [15:0]        baud_reg;
  logic [7:0]         slave_address_reg;
  logic [7:0]         slave_address_mask_reg;
  logic [EV_W-1:0]    int_mask_reg;
  logic [EV_W-1:0]    int_stat_reg;
  logic [EV_W-1:0]    int_stat_next;
  logic [EV_W-1:0]    events;
  logic               rx_done_flag_reg;
  logic               rx_done_flag_next;
  logic               rx_ninth_bit_reg;
  logic               frame_err_reg;
  logic               frame_err_next;
  logic [7:0]         rx_data_reg;
  logic [31:0]        hrdata_reg;

  logic               wr_pend_reg;
  logic [11:0]        wr_addr_reg;
  logic               addr_phase;
  logic               rd_take;
  logic               wr_now;
  logic [11:0]        rd_addr;
  logic [31:0]        rd_mux;

  uaddr_mode_e        mode;
  logic               multiproc_enable;
  logic               rx_enable;
  logic               eleven_bit;

  logic [15:0]        div_cnt_reg;
  logic [15:0]        div_load;
  logic               tick16;

  uaddr_frame_s       frame;
  logic               frame_valid;
  logic               rx_busy;
  logic               addr_match;
  logic               rx_ninth_bit;
  logic               qualifies;
  logic               accept;
  logic               dropped;
  logic               fe_event;

  logic               clr_done;
  logic               clr_fe;
  logic               clr_int;

  // ---------------------------------------------------------------
  // control field decode
  // ---------------------------------------------------------------
  assign mode             = uaddr_mode_e'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  assign multiproc_enable = ctrl_reg[CTRL_MP_BIT];
  assign rx_enable        = ctrl_reg[CTRL_RXEN_BIT] && (mode != UADDR_MODE_SYNC);
  // 11-bit frames carry a programmable ninth bit ahead of the stop bit
  assign eleven_bit       = (mode == UADDR_MODE_FIXED11) || (mode == UADDR_MODE_VAR11);

  // ---------------------------------------------------------------
  // ahb-lite address phase
  // ---------------------------------------------------------------
  // zero wait states: every transfer completes in its first data-phase cycle
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_reg;

  assign addr_phase = hsel_i && htrans_i[1] && hready_i;
  assign rd_take    = addr_phase && !hwrite_i;
  assign rd_addr    = haddr_i[11:0];
  assign wr_now     = wr_pend_reg;

  // writes are held one cycle so hwdata can be taken in the data phase
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= addr_phase && hwrite_i;
      if (addr_phase) wr_addr_reg <= haddr_i[11:0];
    end
  end

  // ---------------------------------------------------------------
  // read data mux
  // ---------------------------------------------------------------
  // unmapped addresses read as zero, the answer is still okay
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (rd_addr)
      UADDR_CTRL_ADDR:          rd_mux[4:0] = ctrl_reg;
      UADDR_BAUD_ADDR:          rd_mux[15:0] = baud_reg;
      UADDR_STAT_ADDR: begin
        rd_mux[STAT_DONE_BIT]  = rx_done_flag_reg;
        rd_mux[STAT_NINTH_BIT] = rx_ninth_bit_reg;
        rd_mux[STAT_FE_BIT]    = frame_err_reg;
        rd_mux[STAT_BUSY_BIT]  = rx_busy;
      end
      UADDR_RXDATA_ADDR:        rd_mux[7:0] = rx_data_reg;
      UADDR_INTSTAT_ADDR:       rd_mux[EV_W-1:0] = int_stat_reg;
      UADDR_INTMASK_ADDR:       rd_mux[EV_W-1:0] = int_mask_reg;
      UADDR_SLAVE_ADDRESS_ADDR: rd_mux[7:0] = slave_address_reg;
      UADDR_SLAVE_MASK_ADDR:    rd_mux[7:0] = slave_address_mask_reg;
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is registered at the address phase and stands in the data phase
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_reg <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // software-written registers
  // ---------------------------------------------------------------
  // control and baud
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= CTRL_RST;
      baud_reg <= BAUD_RST;
    end else if (wr_now) begin
      if (wr_addr_reg == UADDR_CTRL_ADDR) ctrl_reg <= hwdata_i[4:0];
      if (wr_addr_reg == UADDR_BAUD_ADDR) baud_reg <= hwdata_i[15:0];
    end
  end

  // address and mask; zero at reset leaves every bit don't care
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      slave_address_reg      <= SLAVE_ADDRESS_RST;
      slave_address_mask_reg <= SLAVE_MASK_RST;
    end else if (wr_now) begin
      if (wr_addr_reg == UADDR_SLAVE_ADDRESS_ADDR)
        slave_address_reg <= hwdata_i[7:0];
      if (wr_addr_reg == UADDR_SLAVE_MASK_ADDR)
        slave_address_mask_reg <= hwdata_i[7:0];
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      int_mask_reg <= '0;
    end else if (wr_now && (wr_addr_reg == UADDR_INTMASK_ADDR)) begin
      int_mask_reg <= hwdata_i[EV_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // baud divider
  // ---------------------------------------------------------------
  // fixed-rate 11-bit mode ignores the baud register
  assign div_load = (mode == UADDR_MODE_FIXED11)
                  ? (ctrl_reg[CTRL_FAST_BIT] ? FIXED_DIV_FAST : FIXED_DIV_SLOW)
                  : baud_reg;
  assign tick16   = rx_enable && (div_cnt_reg == 16'h0000);

  // down counter gives one oversample enable per 16th of a bit
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !rx_enable) begin
      div_cnt_reg <= 16'h0000;
    end else if (div_cnt_reg == 16'h0000) begin
      div_cnt_reg <= div_load;
    end else begin
      div_cnt_reg <= div_cnt_reg - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // receiver and address compare
  // ---------------------------------------------------------------
  uaddr_rx_frame u_rx (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i),
    .enable_i      (rx_enable),
    .tick16_i      (tick16),
    .nine_bit_i    (eleven_bit),
    .rxd_i         (rxd_i),
    .frame_o       (frame),
    .frame_valid_o (frame_valid),
    .busy_o        (rx_busy)
  );

  // compare runs in hardware on every frame; with multiprocessor mode set software only sees hits
  uaddr_match u_match (
    .byte_i               (frame.data),
    .slave_address_i      (slave_address_reg),
    .slave_address_mask_i (slave_address_mask_reg),
    .match_o              (addr_match)
  );

  // ---------------------------------------------------------------
  // frame acceptance
  // ---------------------------------------------------------------
  // the ninth bit tells address frames from data; in 10-bit mode the stop bit stands in
  assign rx_ninth_bit = eleven_bit ? frame.ninth : frame.stop;
  // multiprocessor mode: only a marked frame whose byte matches gets through
  assign qualifies = !multiproc_enable
                   || (rx_ninth_bit && addr_match);
  // an unread flag blocks the load, the frame is lost
  assign accept    = frame_valid && !rx_done_flag_reg && qualifies;
  assign dropped   = frame_valid && rx_done_flag_reg && qualifies;
  assign fe_event  = frame_valid && !frame.stop;

  // buffer and ninth bit load only with the flag
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_data_reg      <= 8'h00;
      rx_ninth_bit_reg <= 1'b0;
    end else if (accept) begin
      rx_data_reg      <= frame.data;
      rx_ninth_bit_reg <= rx_ninth_bit;
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  // write one to clear; a set in the same cycle wins, but a frame ending in the clearing cycle still sees the old flag and is dropped
  assign clr_done = wr_now && (wr_addr_reg == UADDR_STAT_ADDR) && hwdata_i[STAT_DONE_BIT];
  assign clr_fe   = wr_now && (wr_addr_reg == UADDR_STAT_ADDR) && hwdata_i[STAT_FE_BIT];

  always_comb begin
    rx_done_flag_next = accept || (rx_done_flag_reg && !clr_done);
    frame_err_next    = fe_event || (frame_err_reg && !clr_fe);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_done_flag_reg <= 1'b0;
      frame_err_reg    <= 1'b0;
    end else begin
      rx_done_flag_reg <= rx_done_flag_next;
      frame_err_reg    <= frame_err_next;
    end
  end

  assign rx_done_flag_o = rx_done_flag_reg;

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  assign events[EV_ACCEPT_BIT] = accept;
  assign events[EV_FE_BIT]     = fe_event;
  assign events[EV_DROP_BIT]   = dropped;
  // a read of the status register clears it; events in that cycle survive
  assign clr_int = rd_take && (rd_addr == UADDR_INTSTAT_ADDR);

  always_comb begin
    int_stat_next = events | (clr_int ? '0 : int_stat_reg);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= int_stat_next;
    end
  end

  // level output, high while any unmasked sticky bit stands
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(int_stat_next & int_mask_reg);
    end
  end

endmodule : uart_address_recognition

//--- test/uaddr_chk.sv
`timescale 1ns/1ns
// checker for the address-recognition block, sees its ports only
module uaddr_chk
  import uaddr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic        hreadyout_o,
  input  wire logic        hresp_o,
  input  wire logic [31:0] hrdata_o,
  input  wire logic        rxd_i,
  input  wire logic        rx_done_flag_o,
  input  wire logic        irq_o
);
  // ---------------------------------------------------------------
  // bus shadows
  // ---------------------------------------------------------------
  logic        ph_wr_reg;
  logic [11:0] ph_addr_reg;
  logic [7:0]  sa_reg;
  logic [7:0]  sm_reg;
  logic [4:0]  ctrl_reg;
  logic        take;
  logic        clr_now;

  // a write lands at the edge that ends its data phase
  assign take    = hsel_i & htrans_i[1] & hready_i;
  assign clr_now = ph_wr_reg & hready_i & (ph_addr_reg == UADDR_STAT_ADDR) & hwdata_i[0];

  // remember the pending write phase
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ph_wr_reg <= 1'b0;
    end else if (hready_i) begin
      ph_wr_reg   <= take & hwrite_i;
      ph_addr_reg <= haddr_i[11:0];
    end
  end

  // shadow copies of the registers the properties depend on
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sa_reg   <= SLAVE_ADDRESS_RST;
      sm_reg   <= SLAVE_MASK_RST;
      ctrl_reg <= CTRL_RST;
    end else if (ph_wr_reg && hready_i) begin
      case (ph_addr_reg)
        UADDR_SLAVE_ADDRESS_ADDR: sa_reg <= hwdata_i[7:0];
        UADDR_SLAVE_MASK_ADDR:    sm_reg <= hwdata_i[7:0];
        UADDR_CTRL_ADDR:          ctrl_reg <= hwdata_i[4:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_rd_sa;
    take && !hwrite_i && haddr_i[11:0] == UADDR_SLAVE_ADDRESS_ADDR;
  endsequence
  sequence s_rd_sm;
    take && !hwrite_i && haddr_i[11:0] == UADDR_SLAVE_MASK_ADDR;
  endsequence
  // a frame accepted while multiprocessor mode is on
  sequence s_flag_up_mp;
    $rose(rx_done_flag_o) && ctrl_reg[CTRL_MP_BIT];
  endsequence

  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not zero-wait okay");
  a_slave_address_readback: assert property (s_rd_sa |=> hrdata_o == {24'h000000, $past(sa_reg)})
    else $error("slave address read back wrong");
  a_mask_readback: assert property (s_rd_sm |=> hrdata_o == {24'h000000, $past(sm_reg)})
    else $error("address mask read back wrong");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst_i |=> !rx_done_flag_o && !irq_o)
    else $error("flag or irq high after reset");
  a_flag_clear: assert property (clr_now |=> !rx_done_flag_o)
    else $error("receive flag not cleared by write");
  a_flag_sticky: assert property (rx_done_flag_o && !clr_now |=> rx_done_flag_o)
    else $error("receive flag dropped by itself");
  a_stop_needed: assert property (s_flag_up_mp ##0 ctrl_reg[1:0] == UADDR_MODE_ASYNC10
    |-> $past(rxd_i, 4))
    else $error("flag set on a low stop bit");
  a_ninth_needed: assert property (s_flag_up_mp ##0 ctrl_reg[1] |-> $past(rxd_i, 24))
    else $error("flag set on a data frame");
endmodule : uaddr_chk

bind uart_address_recognition uaddr_chk u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .rxd_i(rxd_i),
  .rx_done_flag_o(rx_done_flag_o), .irq_o(irq_o)
);

//--- test/uaddr_line_model.sv
`timescale 1ns/1ns
// master on the shared serial line; the line idles high between frames
module uaddr_line_model (
  input  wire logic clk_i,
  output logic      rxd_o
);
  initial rxd_o = 1'b1;

  // ---------------------------------------------------------------
  // frame sender, lsb first, start low, stop as asked
  // ---------------------------------------------------------------
  // caller picks the ninth bit: one marks an address frame
  task automatic send_frame(input logic [7:0] d, input logic ninth, input logic stop,
                            input logic eleven, input int bclk);
    logic [10:0] seq;
    int          nb;
    seq = eleven ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
    nb  = eleven ? 11 : 10;
    for (int i = 0; i < nb; i++) begin
      @(posedge clk_i);
      rxd_o <= seq[i];
      repeat (bclk - 1) @(posedge clk_i);
    end
    // back to idle; a low stop leaves no falling edge behind
    @(posedge clk_i);
    rxd_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : send_frame
endmodule : uaddr_line_model

//--- test/testbench.sv
`timescale 1ns/1ns
module testbench
  import uaddr_pkg::*;
;
  typedef struct packed {
    logic       mp;
    logic [1:0] md;
    logic [7:0] b;
    logic       nb;
    logic       st;
    logic       ex;
  } uaddr_tb_row_s;

  logic        clk_i;
  logic        sys_rst_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        rxd;
  logic        flag;
  logic        irq;
  logic [31:0] rd;
  int          failures;
  int          n_compared;

  // given 1010 0x0x, broadcast 1111 111x once address A4h and mask FAh are set
  uaddr_tb_row_s rows [15] = '{
    '{1'b0, UADDR_MODE_ASYNC10, 8'h5A, 1'b0, 1'b1, 1'b1},
    '{1'b0, UADDR_MODE_FIXED11, 8'h5A, 1'b1, 1'b1, 1'b1},
    '{1'b0, UADDR_MODE_VAR11,   8'h3C, 1'b0, 1'b1, 1'b1},
    '{1'b1, UADDR_MODE_VAR11,   8'hA0, 1'b1, 1'b1, 1'b1},
    '{1'b1, UADDR_MODE_VAR11,   8'hA5, 1'b1, 1'b1, 1'b1},
    '{1'b1, UADDR_MODE_VAR11,   8'hA3, 1'b1, 1'b1, 1'b0},
    '{1'b1, UADDR_MODE_VAR11,   8'hA8, 1'b1, 1'b1, 1'b0},
    '{1'b1, UADDR_MODE_FIXED11, 8'hFF, 1'b1, 1'b1, 1'b1},
    '{1'b1, UADDR_MODE_VAR11,   8'hFE, 1'b1, 1'b1, 1'b1},
    '{1'b1, UADDR_MODE_VAR11,   8'hFC, 1'b1, 1'b1, 1'b0},
    '{1'b1, UADDR_MODE_VAR11,   8'hA0, 1'b0, 1'b1, 1'b0},
    '{1'b1, UADDR_MODE_ASYNC10, 8'hA1, 1'b0, 1'b1, 1'b1},
    '{1'b1, UADDR_MODE_ASYNC10, 8'hA1, 1'b0, 1'b0, 1'b0},
    '{1'b1, UADDR_MODE_ASYNC10, 8'h7E, 1'b0, 1'b1, 1'b0},
    '{1'b0, UADDR_MODE_VAR11,   8'h33, 1'b0, 1'b1, 1'b1}
  };

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  uart_address_recognition dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(), .hrdata_o(hrdata),
    .rxd_i(rxd), .rx_done_flag_o(flag), .irq_o(irq)
  );

  uaddr_line_model u_line (.clk_i(clk_i), .rxd_o(rxd));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // bounded wait for hready; running out ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      failures++;
      end_sim();
    end
  endtask : wait_ready

  // one single word transfer, read data left in rd
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus

  // set mode, send one frame, check acceptance and data, then clear status
  task automatic frame(input uaddr_tb_row_s r);
    bus(1'b1, UADDR_CTRL_ADDR, {27'h0000000, 2'b11, r.mp, r.md});
    u_line.send_frame(r.b, r.nb, r.st, r.md[1], (r.md == UADDR_MODE_FIXED11) ? 32 : 16);
    check("flag pin", {31'h00000000, flag}, {31'h00000000, r.ex});
    bus(1'b0, UADDR_STAT_ADDR, 32'h00000000);
    check("frame err", rd & 32'h4, {29'h0, !r.st, 2'h0});
    if (r.ex) begin
      check("ninth bit", {31'h00000000, rd[1]}, {31'h00000000, r.md[1] ? r.nb : r.st});
      bus(1'b0, UADDR_RXDATA_ADDR, 32'h00000000);
      check("rx data", rd, {24'h000000, r.b});
    end
    bus(1'b1, UADDR_STAT_ADDR, 32'h00000005);
  endtask : frame

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    failures   = 0;
    n_compared = 0;
    hsel       = 1'b0;
    haddr      = 32'h00000000;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hwdata     = 32'h00000000;
    sys_rst_i  = 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(1'b0, UADDR_SLAVE_ADDRESS_ADDR, 32'h00000000);
    check("address reset", rd, 32'h00000000);
    bus(1'b0, UADDR_SLAVE_MASK_ADDR, 32'h00000000);
    check("mask reset", rd, 32'h00000000);
    // with both registers clear any address byte is taken
    frame('{1'b1, UADDR_MODE_VAR11, 8'h37, 1'b1, 1'b1, 1'b1});
    bus(1'b1, UADDR_SLAVE_ADDRESS_ADDR, 32'hFFFFFFA4);
    bus(1'b1, UADDR_SLAVE_MASK_ADDR, 32'h000000FA);
    bus(1'b0, UADDR_SLAVE_ADDRESS_ADDR, 32'h00000000);
    check("slave address", rd, 32'h000000A4);
    bus(1'b0, UADDR_SLAVE_MASK_ADDR, 32'h00000000);
    check("address mask", rd, 32'h000000FA);
    bus(1'b1, 12'h100, 32'h000000FF);
    bus(1'b0, 12'h100, 32'h00000000);
    check("unmapped", rd, 32'h00000000);
    foreach (rows[i]) frame(rows[i]);
    // second frame while the flag stands is lost; unmasked accept raises irq
    bus(1'b0, UADDR_INTSTAT_ADDR, 32'h00000000);
    bus(1'b1, UADDR_INTMASK_ADDR, 32'h00000001);
    u_line.send_frame(8'h11, 1'b0, 1'b1, 1'b1, 16);
    check("irq raised", {31'h00000000, irq}, 32'h00000001);
    u_line.send_frame(8'h22, 1'b0, 1'b1, 1'b1, 16);
    bus(1'b0, UADDR_RXDATA_ADDR, 32'h00000000);
    check("held data", rd, 32'h00000011);
    bus(1'b0, UADDR_INTSTAT_ADDR, 32'h00000000);
    check("int status", rd, 32'h00000005);
    bus(1'b1, UADDR_STAT_ADDR, 32'h00000005);
    check("irq cleared", {31'h00000000, irq}, 32'h00000000);
    // masked event: status records it, irq stays low
    bus(1'b1, UADDR_INTMASK_ADDR, 32'h00000000);
    u_line.send_frame(8'h44, 1'b0, 1'b1, 1'b1, 16);
    check("irq masked", {31'h00000000, irq}, 32'h00000000);
    bus(1'b0, UADDR_INTSTAT_ADDR, 32'h00000000);
    check("masked status", rd, 32'h00000001);
    end_sim();
  end
endmodule : testbench
